// *** rtl/cpu_interrupt_sequencer.sv ***
// interrupt acceptance and return sequencer for a small 8-bit core
//
// Summary of operation
// - vectors at lowest addresses, lower is higher priority
// - reset highest, external_irq_zero next
// - take only if source and global enable set
// - accepting clears global enable
// - global enable set in handler allows nesting
// - return_from_irq_instr sets global enable
// - flag cleared by hardware when vectoring
// - writing one clears a flag, zero ignored
// - flag stays latched while source disabled
// - latched flags served by priority once enabled
// - level sources request only while present
// - one instruction runs after return before next
// - status flags not saved or restored
// - disable takes effect in its own cycle
// - instruction after enable runs before service
// - response four cycles, program counter pushed
// - vector jump takes three cycles
// - multi-cycle instruction completes before response
// - wake from sleep adds four cycles
// - return four cycles, pop two, enable set
// - runs on undivided core_clock
// - global enable is status bit seven
// - push lowers stack pointer by two
`timescale 1ns/1ps

module cpu_interrupt_sequencer
	import irq_seq_pkg::*;
#(
	parameter int         NUM_SRC    = 8,
	parameter logic [7:0] LEVEL_MASK = 8'h00
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// interrupt sources
	input  wire logic [NUM_SRC-1:0] irqIn,
	// instruction pipeline
	input  wire coreReq_t          coreReq,
	input  wire logic [11:0]       pcIn,
	output coreRsp_t               coreRsp,
	// stack memory
	output stackReq_t              stackReq,
	input  wire logic [7:0]        stackRdata
);

	// lowest index wins; index 0 is external_irq_zero
	function automatic logic [3:0] prioIdx(input logic [NUM_SRC-1:0] req);
		logic [3:0] idx;
		idx = 4'h0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (req[i]) begin
				idx = 4'(i);
			end
		end
		return idx;
	endfunction : prioIdx

	seqState_t          state_q;
	logic [2:0]         cnt_q;
	logic [NUM_SRC-1:0] flag_q;
	logic [NUM_SRC-1:0] enable_q;
	logic               gie_q;
	logic [15:0]        sp_q;
	logic [11:0]        pcSave_q;
	logic [3:0]         srcSel_q;
	logic [7:0]         popHi_q;
	logic [7:0]         popLo_q;
	logic [1:0]         jmpCnt_q;
	logic               jmpRun_q;
	logic               pcLoad_q;
	logic [11:0]        pcNew_q;
	logic               handlerGo_q;
	logic [NUM_SRC-1:0] levelMask;
	logic [NUM_SRC-1:0] pending;
	logic [NUM_SRC-1:0] request;
	logic               anyReq;
	logic               take;
	logic               retStart;
	logic               pushDone;
	logic               popDone;
	logic               apbWr;
	logic               apbRd;
	logic               addrOk;
	logic [NUM_SRC-1:0] flagW1c;
	logic [NUM_SRC-1:0] vecClr;

	assign levelMask = LEVEL_MASK[NUM_SRC-1:0];

	// flag sources latch; level sources pass live
	assign pending = (flag_q & ~levelMask) | (irqIn & levelMask);
	assign request = pending & enable_q;
	assign anyReq  = |request;

	// only at an instruction boundary or while asleep
	assign take = (state_q == S_IDLE) && anyReq && gie_q
		&& ((coreReq.instrDone && !coreReq.opReti) || coreReq.sleeping)
		&& !(coreReq.instrDone && coreReq.opCli)
		&& !(coreReq.instrDone && coreReq.opSei);

	// the return sets gie_q only when it ends, so the next take waits a boundary
	assign retStart = (state_q == S_IDLE) && coreReq.instrDone && coreReq.opReti;
	assign pushDone = (state_q == S_PUSH) && (cnt_q == 3'(RESP_CYCLES - 1));
	assign popDone  = (state_q == S_POP) && (cnt_q == 3'(RETURN_FROM_IRQ_INSTR_CYCLES - 1));

	assign apbWr  = psel && penable && pwrite;
	assign apbRd  = psel && penable && !pwrite;
	assign addrOk = (paddr == OFF_FLAGS) || (paddr == OFF_ENABLE) || (paddr == OFF_STATUS)
		|| (paddr == OFF_STACK) || (paddr == OFF_STATE);

	assign flagW1c = (apbWr && paddr == OFF_FLAGS) ? pwdata[NUM_SRC-1:0] : '0;

	// sequencer, all on core_clock with no divider
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= S_IDLE;
			cnt_q   <= 3'b000;
		end else begin
			case (state_q)
				S_IDLE: begin
					cnt_q <= 3'b000;
					if (retStart) begin
						state_q <= S_POP;
					end else if (take && coreReq.sleeping) begin
						state_q <= S_WAKE;
					end else if (take) begin
						state_q <= S_PUSH;
					end
				end
				S_WAKE: begin
					if (cnt_q == 3'(WAKE_CYCLES - 1)) begin
						state_q <= S_PUSH;
						cnt_q   <= 3'b000;
					end else begin
						cnt_q <= cnt_q + 3'b001;
					end
				end
				S_PUSH: begin
					if (pushDone) begin
						state_q <= S_IDLE;
					end
					cnt_q <= cnt_q + 3'b001;
				end
				S_POP: begin
					if (popDone) begin
						state_q <= S_IDLE;
					end
					cnt_q <= cnt_q + 3'b001;
				end
				default: begin
					state_q <= S_IDLE;
					cnt_q   <= 3'b000;
				end
			endcase
		end
	end

	// selected source and return address captured at acceptance
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			srcSel_q <= 4'h0;
			pcSave_q <= 12'h000;
		end else if (take) begin
			srcSel_q <= prioIdx(request);
			pcSave_q <= pcIn;
		end
	end

	// clear the vectored flag as the vector is loaded
	always_comb begin
		vecClr = '0;
		if (pushDone) begin
			vecClr[srcSel_q[$clog2(NUM_SRC)-1:0]] = ~levelMask[srcSel_q[$clog2(NUM_SRC)-1:0]];
		end
	end

	// interrupt flags: a new event wins over any clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flag_q <= '0;
		end else begin
			flag_q <= ((flag_q & ~flagW1c & ~vecClr) | irqIn) & ~levelMask;
		end
	end

	// per-source enables
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			enable_q <= ENABLE_RST[NUM_SRC-1:0];
		end else if (apbWr && paddr == OFF_ENABLE) begin
			enable_q <= pwdata[NUM_SRC-1:0];
		end
	end

	// global enable; other status flags are not touched here
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gie_q <= GIE_RST;
		end else if (take) begin
			gie_q <= 1'b0;
		end else if (popDone) begin
			gie_q <= 1'b1;
		end else if (coreReq.instrDone && coreReq.opCli) begin
			gie_q <= 1'b0;
		end else if (coreReq.instrDone && coreReq.opSei) begin
			gie_q <= 1'b1;
		end else if (coreReq.gieWr) begin
			gie_q <= coreReq.gieWrVal;
		end else if (apbWr && paddr == OFF_STATUS) begin
			gie_q <= pwdata[GIE_BIT];
		end
	end

	// stack pointer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sp_q <= STACK_RST;
		end else if (pushDone) begin
			sp_q <= sp_q - 16'h0002;
		end else if (popDone) begin
			sp_q <= sp_q + 16'h0002;
		end else if (apbWr && paddr == OFF_STACK && state_q == S_IDLE) begin
			sp_q <= pwdata[15:0];
		end
	end

	// stack memory requests: low byte at sp, high at sp-1; pop reversed
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stackReq <= '0;
		end else begin
			stackReq <= '0;
			if (state_q == S_PUSH && cnt_q == 3'b000) begin
				stackReq.we    <= 1'b1;
				stackReq.addr  <= sp_q;
				stackReq.wdata <= pcSave_q[7:0];
			end else if (state_q == S_PUSH && cnt_q == 3'b001) begin
				stackReq.we    <= 1'b1;
				stackReq.addr  <= sp_q - 16'h0001;
				stackReq.wdata <= {4'h0, pcSave_q[11:8]};
			end else if (retStart) begin
				stackReq.re   <= 1'b1;
				stackReq.addr <= sp_q + 16'h0001;
			end else if (state_q == S_POP && cnt_q == 3'b000) begin
				stackReq.re   <= 1'b1;
				stackReq.addr <= sp_q + 16'h0002;
			end
		end
	end

	// capture popped bytes, each one cycle after its read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			popHi_q <= 8'h00;
			popLo_q <= 8'h00;
		end else if (state_q == S_POP && cnt_q == 3'b001) begin
			popHi_q <= stackRdata;
		end else if (state_q == S_POP && cnt_q == 3'b010) begin
			popLo_q <= stackRdata;
		end
	end

	// program counter load at the end of entry and of return
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pcLoad_q <= 1'b0;
			pcNew_q  <= RESET_VEC;
		end else begin
			pcLoad_q <= pushDone || popDone;
			if (pushDone) begin
				pcNew_q <= RESET_VEC + 12'(srcSel_q) + 12'h001;
			end else if (popDone) begin
				pcNew_q <= {popHi_q[3:0], popLo_q};
			end
		end
	end

	// vector jump timing, ends with handler entry pulse
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			jmpRun_q    <= 1'b0;
			jmpCnt_q    <= 2'b00;
			handlerGo_q <= 1'b0;
		end else begin
			handlerGo_q <= 1'b0;
			if (pushDone) begin
				jmpRun_q <= 1'b1;
				jmpCnt_q <= 2'b00;
			end else if (jmpRun_q && jmpCnt_q == 2'(JUMP_CYCLES - 1)) begin
				jmpRun_q    <= 1'b0;
				handlerGo_q <= 1'b1;
			end else if (jmpRun_q) begin
				jmpCnt_q <= jmpCnt_q + 2'b01;
			end
		end
	end

	// pipeline held while entry or return runs
	// one driver for the whole response word
	assign coreRsp = '{
		hold:      (state_q != S_IDLE),
		pcLoad:    pcLoad_q,
		pcNew:     pcNew_q,
		handlerGo: handlerGo_q,
		gie:       gie_q
	};

	// apb slave: zero wait states, error on unmapped address
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !addrOk;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= 32'h0000_0000;
			case (paddr)
				OFF_FLAGS:  prdata[NUM_SRC-1:0] <= pending;
				OFF_ENABLE: prdata[NUM_SRC-1:0] <= enable_q;
				OFF_STATUS: prdata[GIE_BIT]     <= gie_q;
				OFF_STACK:  prdata[15:0]        <= sp_q;
				OFF_STATE:  prdata[11:0]        <= {jmpRun_q, state_q, srcSel_q, 4'h0};
				default:    prdata              <= 32'h0000_0000;
			endcase
		end
	end

endmodule : cpu_interrupt_sequencer

// *** inc/irq_seq_pkg.sv ***
// constants, map and carrier types of the interrupt sequencer
package irq_seq_pkg;

	// apb register offsets
	localparam logic [7:0] OFF_FLAGS  = 8'h00;
	localparam logic [7:0] OFF_ENABLE = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_STACK  = 8'h0C;
	localparam logic [7:0] OFF_STATE  = 8'h10;

	// field positions and reset values
	localparam int          GIE_BIT     = 7;
	localparam logic [7:0]  ENABLE_RST  = 8'h00;
	localparam logic [15:0] STACK_RST   = 16'h0000;
	localparam logic        GIE_RST     = 1'b0;

	// sequence lengths in core_clock cycles
	localparam int RESP_CYCLES = 4;
	localparam int WAKE_CYCLES = 4;
	localparam int RETURN_FROM_IRQ_INSTR_CYCLES = 4;
	localparam int JUMP_CYCLES = 3;

	// reset owns vector zero
	localparam logic [11:0] RESET_VEC = 12'h000;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_WAKE = 3'b001,
		S_PUSH = 3'b010,
		S_POP  = 3'b011
	} seqState_t;

	// from the instruction pipeline
	typedef struct packed {
		logic instrDone;
		logic opSei;
		logic opCli;
		logic opReti;
		logic sleeping;
		logic gieWr;
		logic gieWrVal;
	} coreReq_t;

	// to the instruction pipeline
	typedef struct packed {
		logic        hold;
		logic        pcLoad;
		logic [11:0] pcNew;
		logic        handlerGo;
		logic        gie;
	} coreRsp_t;

	// stack memory port
	typedef struct packed {
		logic        we;
		logic        re;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} stackReq_t;

endpackage : irq_seq_pkg

// *** bench/stack_mem.sv ***
// stack memory model at the sequencer's stack port
`timescale 1ns/1ps
module stack_mem
	import irq_seq_pkg::*;
(
	// clock
	input  wire logic      clk,
	// stack port
	input  wire stackReq_t stackReq,
	output logic [7:0]     stackRdata
);
	logic [7:0] mem [logic [15:0]];

	initial stackRdata = 8'h00;

	// byte store, read data the cycle after re, garbage otherwise
	always @(posedge clk) begin
		if (stackReq.we)
			mem[stackReq.addr] = stackReq.wdata;
		if (stackReq.re && mem.exists(stackReq.addr))
			stackRdata <= mem[stackReq.addr];
		else
			stackRdata <= ~stackRdata;
	end
endmodule : stack_mem

// *** bench/cpu_interrupt_sequencer_asserts.sv ***
// assertions on the sequencer's core and stack ports
`timescale 1ns/1ps
module cpu_interrupt_sequencer_asserts
	import irq_seq_pkg::*;
(
	// clock and reset
	input wire logic      clk,
	input wire logic      rst,
	// core and stack
	input wire coreReq_t  coreReq,
	input wire coreRsp_t  coreRsp,
	input wire stackReq_t stackReq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_push;
		coreRsp.hold [*4] ##1 (!coreRsp.hold && coreRsp.pcLoad);
	endsequence
	sequence s_wake;
		coreRsp.hold [*8] ##1 coreRsp.pcLoad;
	endsequence
	sequence s_pop;
		coreRsp.hold [*4] ##1 (coreRsp.pcLoad && coreRsp.gie);
	endsequence

	property p_entry;
		$rose(coreRsp.hold) && !$past(coreReq.instrDone && coreReq.opReti)
			&& !$past(coreReq.sleeping) |-> s_push;
	endproperty
	property p_wake;
		$rose(coreRsp.hold) && !$past(coreReq.instrDone && coreReq.opReti)
			&& $past(coreReq.sleeping) |-> s_wake;
	endproperty
	property p_gie;
		$rose(coreRsp.hold) && !$past(coreReq.instrDone && coreReq.opReti) |-> !coreRsp.gie;
	endproperty
	property p_ret;
		coreReq.instrDone && coreReq.opReti && !coreRsp.hold |=> s_pop;
	endproperty
	property p_cli;
		coreReq.instrDone && coreReq.opCli && !coreRsp.hold |=> !coreRsp.hold && !coreRsp.gie;
	endproperty
	property p_sei;
		coreReq.instrDone && coreReq.opSei && !coreRsp.hold |=> !coreRsp.hold && coreRsp.gie;
	endproperty
	property p_off;
		!coreRsp.gie && !coreRsp.hold && !(coreReq.instrDone && coreReq.opReti) |=> !coreRsp.hold;
	endproperty
	property p_go;
		coreRsp.pcLoad && $past(stackReq.we, 2) |-> ##3 coreRsp.handlerGo;
	endproperty
	property p_we;
		$rose(stackReq.we) |=> stackReq.we && stackReq.addr == $past(stackReq.addr) - 16'h0001;
	endproperty
	property p_re;
		$rose(stackReq.re) |=> stackReq.re && stackReq.addr == $past(stackReq.addr) + 16'h0001;
	endproperty

	a_entry: assert property (p_entry) else $error("entry timing wrong");
	a_wake: assert property (p_wake) else $error("wake timing wrong");
	a_gie: assert property (p_gie) else $error("gie kept on entry");
	a_ret: assert property (p_ret) else $error("return timing wrong");
	a_cli: assert property (p_cli) else $error("take after disable");
	a_sei: assert property (p_sei) else $error("take with enable");
	a_off: assert property (p_off) else $error("take with gie low");
	a_go: assert property (p_go) else $error("jump time wrong");
	a_we: assert property (p_we) else $error("push order wrong");
	a_re: assert property (p_re) else $error("pop order wrong");
endmodule : cpu_interrupt_sequencer_asserts

bind cpu_interrupt_sequencer cpu_interrupt_sequencer_asserts i_cpu_interrupt_sequencer_asserts (
	.clk, .rst, .coreReq, .coreRsp, .stackReq);

// *** bench/cpu_interrupt_sequencer_tb.sv ***
// testbench of the interrupt sequencer
`timescale 1ns/1ps
module cpu_interrupt_sequencer_tb
	import irq_seq_pkg::*;
;
	logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        pready, pslverr, err;
	logic [7:0]  paddr = 8'h00, irqIn = 8'h00, stackRdata;
	logic [31:0] pwdata = 32'h0000_0000, prdata, r;
	logic [11:0] pcIn = 12'h234;
	coreReq_t    coreReq = '0;
	coreRsp_t    coreRsp;
	stackReq_t   stackReq;
	int          n_fail = 0, n_tests = 0;

	always #5 clk = ~clk;

	cpu_interrupt_sequencer #(.NUM_SRC(8), .LEVEL_MASK(8'h80)) i_cpu_interrupt_sequencer (
		.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irqIn(irqIn), .coreReq(coreReq), .pcIn(pcIn),
		.coreRsp(coreRsp), .stackReq(stackReq), .stackRdata(stackRdata));
	stack_mem i_stack_mem (.clk(clk), .stackReq(stackReq), .stackRdata(stackRdata));

	task results;
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results

	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h seen %h", n, e, s);
		end
	endtask : chk

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20) begin
			n_fail++;
			results();
		end
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task pulse(input logic [7:0] m);
		@(posedge clk);
		irqIn <= m;
		@(posedge clk);
		irqIn <= 8'h00;
	endtask : pulse

	// op is {enable, disable, return}
	task instr(input logic [2:0] op);
		@(posedge clk);
		coreReq.instrDone <= 1'b1;
		coreReq.opSei <= op[2];
		coreReq.opCli <= op[1];
		coreReq.opReti <= op[0];
		@(posedge clk);
		coreReq.instrDone <= 1'b0;
	endtask : instr

	task vec(input logic [11:0] e);
		int i;
		for (i = 0; i < 40; i++) begin
			@(posedge clk);
			if (coreRsp.pcLoad === 1'b1)
				break;
		end
		if (i == 40) begin
			n_fail++;
			results();
		end
		chk("pcNew", {20'h0_0000, coreRsp.pcNew}, {20'h0_0000, e});
	endtask : vec

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, OFF_STACK, '0);
		chk("stack", r, {16'h0000, STACK_RST});
		apb(1'b0, OFF_STATUS, '0);
		chk("status", r, 32'h0000_0000);
		apb(1'b0, 8'h14, '0);
		chk("slverr", {31'h0, err}, 32'h0000_0001);
		$display("reset test done");
		apb(1'b1, OFF_STACK, 32'h0000_0100);
		apb(1'b1, OFF_ENABLE, 32'h0000_0007);
		pulse(8'h0F);
		apb(1'b0, OFF_FLAGS, '0);
		chk("flags", r, 32'h0000_000F);
		apb(1'b1, OFF_FLAGS, 32'h0000_0008);
		apb(1'b1, OFF_FLAGS, 32'h0000_0000);
		apb(1'b0, OFF_FLAGS, '0);
		chk("flags", r, 32'h0000_0007);
		instr(3'b000);
		@(posedge clk);
		chk("hold", {31'h0, coreRsp.hold}, 32'h0000_0000);
		apb(1'b1, OFF_STATUS, 32'h0000_0080);
		instr(3'b000);
		vec(12'h001);
		chk("gie", {31'h0, coreRsp.gie}, 32'h0000_0000);
		apb(1'b0, OFF_FLAGS, '0);
		chk("flags", r, 32'h0000_0006);
		apb(1'b0, OFF_STACK, '0);
		chk("stack", r, 32'h0000_00FE);
		chk("low byte", {24'h0, i_stack_mem.mem[16'h0100]}, 32'h0000_0034);
		instr(3'b001);
		vec(pcIn);
		chk("gie", {31'h0, coreRsp.gie}, 32'h0000_0001);
		apb(1'b0, OFF_STACK, '0);
		chk("stack", r, 32'h0000_0100);
		instr(3'b000);
		vec(12'h002);
		instr(3'b001);
		vec(pcIn);
		$display("priority test done");
		instr(3'b010);
		@(posedge clk);
		chk("gie", {31'h0, coreRsp.gie}, 32'h0000_0000);
		chk("hold", {31'h0, coreRsp.hold}, 32'h0000_0000);
		instr(3'b100);
		@(posedge clk);
		chk("hold", {31'h0, coreRsp.hold}, 32'h0000_0000);
		instr(3'b000);
		vec(12'h003);
		apb(1'b1, OFF_STATUS, 32'h0000_0080);
		pulse(8'h01);
		instr(3'b000);
		vec(12'h001);
		instr(3'b001);
		vec(pcIn);
		instr(3'b001);
		vec(pcIn);
		coreReq.sleeping <= 1'b1;
		pulse(8'h02);
		vec(12'h002);
		coreReq.sleeping <= 1'b0;
		instr(3'b001);
		vec(pcIn);
		$display("nesting and sleep test done");
		@(posedge clk);
		irqIn <= 8'h80;
		apb(1'b0, OFF_FLAGS, '0);
		chk("level", r, 32'h0000_0080);
		irqIn <= 8'h00;
		apb(1'b0, OFF_FLAGS, '0);
		chk("level", r, 32'h0000_0000);
		apb(1'b1, OFF_ENABLE, 32'h0000_0087);
		instr(3'b000);
		@(posedge clk);
		chk("hold", {31'h0, coreRsp.hold}, 32'h0000_0000);
		irqIn <= 8'h80;
		instr(3'b000);
		vec(12'h008);
		irqIn <= 8'h00;
		repeat (JUMP_CYCLES) @(posedge clk);
		chk("go", {31'h0, coreRsp.handlerGo}, 32'h0000_0001);
		coreReq.gieWr <= 1'b1;
		coreReq.gieWrVal <= 1'b1;
		@(posedge clk);
		coreReq.gieWr <= 1'b0;
		@(posedge clk);
		chk("gie", {31'h0, coreRsp.gie}, 32'h0000_0001);
		$display("level test done");
		results();
	end
endmodule : cpu_interrupt_sequencer_tb
